/* File: rtl/ppfs_params.svh */
// ppfs_params.svh: offsets, reset values, code points and masks of the
// port pin-function select block.
// assumes: included by bare name before ppfs_pkg and the design modules.
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH

// ----------------------------------------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------------------------------------
`define PPFS_OFS_D        8'h00
`define PPFS_OFS_E        8'h04
`define PPFS_OFS_F        8'h08
`define PPFS_OFS_G        8'h0C
`define PPFS_OFS_STAT     8'h10

// ----------------------------------------------------------------------
// power-on values, strap high / strap low
// ----------------------------------------------------------------------
`define PPFS_RST_D        16'h2200
`define PPFS_RST_E_HI     16'hAAAA
`define PPFS_RST_E_LO     16'h2AA8
`define PPFS_RST_F_HI     16'hAAAA
`define PPFS_RST_F_LO     16'h00AA
`define PPFS_RST_G_HI     16'hAAAA
`define PPFS_RST_G_LO     16'hA200

// ----------------------------------------------------------------------
// field codes and per-pin masks
// ----------------------------------------------------------------------
`define PPFS_CODE_ALT     2'h0
`define PPFS_CODE_OUT     2'h1
`define PPFS_CODE_IN_PU   2'h2
`define PPFS_CODE_IN_NOPU 2'h3
`define PPFS_WMASK_D      16'h3300
`define PPFS_IMPL_D       8'h50
`define PPFS_IMPL_ALL     8'hFF
`define PPFS_RES00_D      8'h00
`define PPFS_RES01_D      8'h50
`define PPFS_RES00_E      8'hCB
`define PPFS_RES01_E      8'h00
`define PPFS_RES00_F      8'h00
`define PPFS_RES01_F      8'hFF
`define PPFS_RES00_G      8'h00
`define PPFS_RES01_G      8'hFF
`define PPFS_G0_UPPER_BIT 3

// ----------------------------------------------------------------------
// status word layout
// ----------------------------------------------------------------------
`define PPFS_STAT_STRAP   0
`define PPFS_STAT_RSV_LSB 4
`define PPFS_STAT_RSV_MSB 7

`endif

/* File: rtl/ppfs_pkg.sv */
// ppfs_pkg: types shared by the pin-function select modules.
// assumes: ppfs_params.svh is on the include path.
`include "ppfs_params.svh"

package ppfs_pkg;

  // ----------------------------------------------------------------------
  // per-port decoded roles, one bit per pin
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] alt_en;
    logic [7:0] out_en;
    logic [7:0] in_en;
    logic [7:0] pull_en;
  } ppfs_port_role_s;

  // ----------------------------------------------------------------------
  // wishbone request carrier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ppfs_wb_req_s;

  typedef enum logic [1:0] {
    PPFS_ST_CAPTURE = 2'b01,
    PPFS_ST_RUN     = 2'b10
  } ppfs_state_e;

  typedef struct packed {
    ppfs_state_e     st;
    logic            strap;
    logic            pin6;
    logic [15:0]     ctrl_d;
    logic [15:0]     ctrl_e;
    logic [15:0]     ctrl_f;
    logic [15:0]     ctrl_g;
    logic            ack;
    logic [31:0]     rdat;
    logic [3:0]      rsv;
    ppfs_port_role_s role_d;
    ppfs_port_role_s role_e;
    ppfs_port_role_s role_f;
    ppfs_port_role_s role_g;
  } ppfs_state_s;

endpackage : ppfs_pkg

/* File: rtl/ppfs_sync.sv */
// ppfs_sync: multi-stage synchroniser for one pad level.
// assumes: clock keeps running while reset is asserted.
`timescale 1ns/1ps

module ppfs_sync #(
  parameter int STAGES = 2
) (
  // clock
  input  wire logic mclk_i,
  // pad level and synchronised copy
  input  wire logic d_i,
  output logic      q_o
);

  // no reset on purpose: the strap level must flow through while
  // power-on reset holds the rest of the block
  logic [STAGES-1:0] sync_r;
  logic [STAGES-1:0] sync_nxt;

  if (STAGES < 2) begin : g_chk
    $error("ppfs_sync needs at least two stages");
  end

  always_comb begin
    sync_nxt = {sync_r[STAGES-2:0], d_i};
  end

  always_ff @(posedge mclk_i) begin
    sync_r <= sync_nxt;
  end

  assign q_o = sync_r[STAGES-1];

endmodule : ppfs_sync

/* File: rtl/ppfs_role_decode.sv */
// ppfs_role_decode: turns one 16-bit pin-field word into per-pin roles.
// assumes: masks come from ppfs_params.svh; output is registered by the user.
`timescale 1ns/1ps

module ppfs_role_decode
  import ppfs_pkg::*;
#(
  parameter logic [7:0] RES00    = 8'h00,
  parameter logic [7:0] RES01    = 8'h00,
  parameter logic [7:0] IMPL     = 8'hFF,
  parameter bit         G0_SPLIT = 1'b0
) (
  // control word
  input  wire logic [15:0] ctrl_i,
  // decoded roles and reserved-code flag
  output ppfs_port_role_s  role_o,
  output logic             rsv_o
);

  logic [7:0] alt;
  logic [7:0] out;
  logic [7:0] inp;
  logic [7:0] pull;
  logic [7:0] rsv;

  if ((RES00 & RES01) != 8'h00) begin : g_chk
    $error("ppfs_role_decode: a pin cannot reserve both 00 and 01");
  end

  for (genvar p = 0; p < 8; p++) begin : g_pin
    logic [1:0] code;
    logic       bad;
    if (G0_SPLIT && p == 0) begin : g_split
      assign code = {ctrl_i[`PPFS_G0_UPPER_BIT], ctrl_i[0]};
    end else begin : g_plain
      assign code = ctrl_i[2*p+1:2*p];
    end
    // reserved codes fall back to input with pull-up
    assign bad     = (code == `PPFS_CODE_ALT && RES00[p]) ||
                     (code == `PPFS_CODE_OUT && RES01[p]);
    assign alt[p]  = IMPL[p] && !bad && code == `PPFS_CODE_ALT;
    assign out[p]  = IMPL[p] && !bad && code == `PPFS_CODE_OUT;
    assign inp[p]  = IMPL[p] && (bad || code[1]);
    assign pull[p] = IMPL[p] && (bad || code == `PPFS_CODE_IN_PU);
    assign rsv[p]  = IMPL[p] && bad;
  end

  assign role_o = '{alt_en: alt, out_en: out, in_en: inp, pull_en: pull};
  assign rsv_o  = |rsv;

endmodule : ppfs_role_decode

/* File: rtl/ppfs_top.sv */
// ppfs_top: pin-function select registers for port D pins 4/6 and
// ports E, F and G, as a classic wishbone slave with 32-bit data.
// assumes: rst_b_i is the power-on reset; mclk_i runs during reset;
// port_g_pin6_pad_i comes straight from the pad.
`timescale 1ns/1ps
`include "ppfs_params.svh"

// Function
// - each port control word is 16 bits, RW, pin n in bits 2n+1 and 2n.
// - code 00 alternate, 10 input pull-up, 11 input no pull-up, 01 output.
// - port D pins 4 and 6 reserve 01; reset to input with pull-up.
// - port E resets to AAAA with strap high, 2AA8 with strap low.
// - only power-on reset loads the words; manual reset leaves them alone.
// - port E pins 0 and 7 reserve 00; 01 output; strap picks 10 or 00.
// - port E pins 2,4,5 alternate on 00, pins 1,3,6 reserve it; reset pull-up.
// - port F resets to AAAA with strap high, 00AA with strap low.
// - port F pins 4-7 reserve 01; reset 00 strap low, 10 strap high.
// - port F pins 0-3 reserve 01; always reset to input with pull-up.
// - port G resets to AAAA with strap high, A200 with strap low.
// - port G pins 1-3 and 5 reserve 01; reset 00 or 10 by strap.
// - port G pins 4, 6, 7 reserve 01; reset to input with pull-up.
// - port G pin 6 is the strap during reset, plain input after it.
// - port G pin 0 decodes bit 3 as upper select and bit 0 as lower.
module ppfs_top
  import ppfs_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and resets
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        mrst_b_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // strap / port G pin 6 pad
  input  wire logic        port_g_pin6_pad_i,
  // decoded pin roles, port G pin 6 input level and captured strap
  output ppfs_port_role_s  port_d_role_o,
  output ppfs_port_role_s  port_e_role_o,
  output ppfs_port_role_s  port_f_role_o,
  output ppfs_port_role_s  port_g_role_o,
  output logic             port_g_pin6_input_o,
  output logic             debug_mode_strap_o
);

  // ----------------------------------------------------------------------
  // local signals
  // ----------------------------------------------------------------------
  ppfs_state_s     s_r;
  ppfs_state_s     s_nxt;
  ppfs_wb_req_s    req;
  logic            pad_sync;
  logic            hit;
  logic            wr_en;
  logic [15:0]     wr_d;
  logic [15:0]     wr_e;
  logic [15:0]     wr_f;
  logic [15:0]     wr_g;
  ppfs_port_role_s dec_d;
  ppfs_port_role_s dec_e;
  ppfs_port_role_s dec_f;
  ppfs_port_role_s dec_g;
  logic [3:0]      dec_rsv;

  if (SYNC_STAGES < 2) begin : g_chk
    $error("ppfs_top needs at least two synchroniser stages");
  end

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // byte-lane merge of a 16-bit word, under a mask of writable bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel,
                                             input logic [15:0] wmask);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    lane_merge = (res & wmask) | (old & ~wmask);
  endfunction : lane_merge

  function automatic logic is_mapped(input logic [7:0] adr);
    is_mapped = (adr == `PPFS_OFS_D) || (adr == `PPFS_OFS_E) ||
                (adr == `PPFS_OFS_F) || (adr == `PPFS_OFS_G) ||
                (adr == `PPFS_OFS_STAT);
  endfunction : is_mapped

  // ----------------------------------------------------------------------
  // strap pad synchroniser
  // ----------------------------------------------------------------------
  ppfs_sync #(
    .STAGES (SYNC_STAGES)
  ) u_strap_sync (
    .mclk_i (mclk_i),
    .d_i    (port_g_pin6_pad_i),
    .q_o    (pad_sync)
  );

  // ----------------------------------------------------------------------
  // role decoders
  // ----------------------------------------------------------------------
  ppfs_role_decode #(
    .RES00    (`PPFS_RES00_D),
    .RES01    (`PPFS_RES01_D),
    .IMPL     (`PPFS_IMPL_D),
    .G0_SPLIT (1'b0)
  ) u_dec_d (
    .ctrl_i (s_r.ctrl_d),
    .role_o (dec_d),
    .rsv_o  (dec_rsv[0])
  );

  ppfs_role_decode #(
    .RES00    (`PPFS_RES00_E),
    .RES01    (`PPFS_RES01_E),
    .IMPL     (`PPFS_IMPL_ALL),
    .G0_SPLIT (1'b0)
  ) u_dec_e (
    .ctrl_i (s_r.ctrl_e),
    .role_o (dec_e),
    .rsv_o  (dec_rsv[1])
  );

  ppfs_role_decode #(
    .RES00    (`PPFS_RES00_F),
    .RES01    (`PPFS_RES01_F),
    .IMPL     (`PPFS_IMPL_ALL),
    .G0_SPLIT (1'b0)
  ) u_dec_f (
    .ctrl_i (s_r.ctrl_f),
    .role_o (dec_f),
    .rsv_o  (dec_rsv[2])
  );

  ppfs_role_decode #(
    .RES00    (`PPFS_RES00_G),
    .RES01    (`PPFS_RES01_G),
    .IMPL     (`PPFS_IMPL_ALL),
    .G0_SPLIT (1'b1)
  ) u_dec_g (
    .ctrl_i (s_r.ctrl_g),
    .role_o (dec_g),
    .rsv_o  (dec_rsv[3])
  );

  // ----------------------------------------------------------------------
  // bus write path
  // ----------------------------------------------------------------------
  // write lands on the edge where the master sees ack, not before;
  // manual reset blocks it so the words stay put
  assign hit   = req.cyc && req.stb;
  assign wr_en = hit && req.we && s_r.ack && mrst_b_i;
  assign wr_d  = lane_merge(s_r.ctrl_d, req.dat, req.sel, `PPFS_WMASK_D);
  assign wr_e  = lane_merge(s_r.ctrl_e, req.dat, req.sel, 16'hFFFF);
  assign wr_f  = lane_merge(s_r.ctrl_f, req.dat, req.sel, 16'hFFFF);
  assign wr_g  = lane_merge(s_r.ctrl_g, req.dat, req.sel, 16'hFFFF);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      PPFS_ST_CAPTURE: begin
        // first edge after power-on release: strap decides the values
        s_nxt.st     = PPFS_ST_RUN;
        s_nxt.strap  = pad_sync;
        s_nxt.ctrl_d = `PPFS_RST_D;
        s_nxt.ctrl_e = pad_sync ? `PPFS_RST_E_HI : `PPFS_RST_E_LO;
        s_nxt.ctrl_f = pad_sync ? `PPFS_RST_F_HI : `PPFS_RST_F_LO;
        s_nxt.ctrl_g = pad_sync ? `PPFS_RST_G_HI : `PPFS_RST_G_LO;
        s_nxt.ack    = 1'b0;
      end
      PPFS_ST_RUN: begin
        s_nxt.st = PPFS_ST_RUN;
        if (wr_en) begin
          case (req.adr)
            `PPFS_OFS_D: begin
              s_nxt.ctrl_d = wr_d;
            end
            `PPFS_OFS_E: begin
              s_nxt.ctrl_e = wr_e;
            end
            `PPFS_OFS_F: begin
              s_nxt.ctrl_f = wr_f;
            end
            `PPFS_OFS_G: begin
              s_nxt.ctrl_g = wr_g;
            end
            default: begin
              s_nxt.ctrl_d = s_r.ctrl_d;
            end
          endcase
        end
        // ack for one cycle per request; unmapped offsets are acked too
        s_nxt.ack = hit && !s_r.ack && mrst_b_i;
        if (hit && !s_r.ack) begin
          case (req.adr)
            `PPFS_OFS_D: begin
              s_nxt.rdat = {16'h0000, s_r.ctrl_d};
            end
            `PPFS_OFS_E: begin
              s_nxt.rdat = {16'h0000, s_r.ctrl_e};
            end
            `PPFS_OFS_F: begin
              s_nxt.rdat = {16'h0000, s_r.ctrl_f};
            end
            `PPFS_OFS_G: begin
              s_nxt.rdat = {16'h0000, s_r.ctrl_g};
            end
            `PPFS_OFS_STAT: begin
              s_nxt.rdat = 32'h0000_0000;
              s_nxt.rdat[`PPFS_STAT_STRAP] = s_r.strap;
              s_nxt.rdat[`PPFS_STAT_RSV_MSB:`PPFS_STAT_RSV_LSB] = s_r.rsv;
            end
            default: begin
              s_nxt.rdat = 32'h0000_0000;
            end
          endcase
        end
      end
      default: begin
        s_nxt.st  = PPFS_ST_CAPTURE;
        s_nxt.ack = 1'b0;
      end
    endcase
    // pin 6 only serves as a port input once out of reset
    s_nxt.pin6   = (s_r.st == PPFS_ST_RUN) ? pad_sync : 1'b0;
    s_nxt.rsv    = dec_rsv;
    s_nxt.role_d = dec_d;
    s_nxt.role_e = dec_e;
    s_nxt.role_f = dec_f;
    s_nxt.role_g = dec_g;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // only the power-on reset loads the words with their strap-high values; mrst_b_i is not wired here
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r        <= '0;
      s_r.st     <= PPFS_ST_CAPTURE;
      s_r.ctrl_d <= `PPFS_RST_D;
      s_r.ctrl_e <= `PPFS_RST_E_HI;
      s_r.ctrl_f <= `PPFS_RST_F_HI;
      s_r.ctrl_g <= `PPFS_RST_G_HI;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o            = s_r.rdat;
  assign wb_ack_o            = s_r.ack;
  assign port_d_role_o       = s_r.role_d;
  assign port_e_role_o       = s_r.role_e;
  assign port_f_role_o       = s_r.role_f;
  assign port_g_role_o       = s_r.role_g;
  assign port_g_pin6_input_o = s_r.pin6;
  assign debug_mode_strap_o  = s_r.strap;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_ack_single_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_r.ack |=> !s_r.ack)
    else $error("ack held longer than one cycle");

  a_write_e_lands: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_en && req.adr == `PPFS_OFS_E && req.sel[1:0] == 2'b11)
    |=> s_r.ctrl_e == $past(req.dat[15:0]))
    else $error("port E write did not land");

  a_d_mask_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (s_r.ctrl_d & ~`PPFS_WMASK_D) == 16'h0000)
    else $error("port D unimplemented bits set");

  // sampled reset keeps the release edge out: the words still hold their reset copy there
  a_e_reset_strap: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rst_b_i && s_r.st == PPFS_ST_CAPTURE
    |=> s_r.ctrl_e == ($past(pad_sync) ? `PPFS_RST_E_HI : `PPFS_RST_E_LO))
    else $error("port E reset value wrong");

  a_f_reset_strap: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rst_b_i && s_r.st == PPFS_ST_CAPTURE
    |=> s_r.ctrl_f == ($past(pad_sync) ? `PPFS_RST_F_HI : `PPFS_RST_F_LO))
    else $error("port F reset value wrong");

  a_g_reset_strap: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rst_b_i && s_r.st == PPFS_ST_CAPTURE
    |=> s_r.ctrl_g == ($past(pad_sync) ? `PPFS_RST_G_HI : `PPFS_RST_G_LO) ##1 s_r.role_g.in_en[4])
    else $error("port G reset value wrong");

  a_mrst_keeps_words: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!mrst_b_i && s_r.st == PPFS_ST_RUN)
    |=> $stable(s_r.ctrl_e) && $stable(s_r.ctrl_f) && $stable(s_r.ctrl_g) && !s_r.ack)
    else $error("manual reset disturbed control words");

  a_f_no_output: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_r.role_f.out_en == 8'h00 && s_r.role_g.out_en == 8'h00)
    else $error("output role on a port without one");

  a_e_pin1_output: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_r.ctrl_e[3:2] == `PPFS_CODE_OUT |=> s_r.role_e.out_en[1])
    else $error("port E pin 1 output not decoded");

  a_g0_split_alt: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (s_r.ctrl_g[`PPFS_G0_UPPER_BIT] == 1'b0 && s_r.ctrl_g[0] == 1'b0)
    |=> s_r.role_g.alt_en[0] && !s_r.role_g.in_en[0])
    else $error("port G pin 0 not decoded from bits 3 and 0");

  a_strap_frozen: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_r.st == PPFS_ST_RUN |=> $stable(s_r.strap))
    else $error("captured strap changed after reset");

  a_pin6_follows: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (s_r.st == PPFS_ST_RUN) ##1 (s_r.st == PPFS_ST_RUN) |=> s_r.pin6 == $past(pad_sync))
    else $error("pin 6 input does not follow the pad");

  a_d_reserved_pu: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_r.ctrl_d[9:8] == `PPFS_CODE_OUT |=> s_r.role_d.pull_en[4] && s_r.rsv[0])
    else $error("port D reserved code not handled");

endmodule : ppfs_top

/* File: tb/ppfs_top_test.sv */
// ppfs_top_test: self-checking bench for the pin-function select block.
// assumes: ppfs_params.svh on the include path; slave acks in one cycle.
`timescale 1ns/1ps
`include "ppfs_params.svh"

module ppfs_top_test
  import ppfs_pkg::*;
;
  logic            mclk_i;
  logic            rst_b_i;
  logic            mrst_b_i;
  logic            cyc;
  logic            stb;
  logic            we;
  logic [3:0]      sel;
  logic [7:0]      adr;
  logic [31:0]     wdat;
  logic [31:0]     rdat;
  logic            ack;
  logic            pad;
  ppfs_port_role_s role_d;
  ppfs_port_role_s role_e;
  ppfs_port_role_s role_f;
  ppfs_port_role_s role_g;
  logic            pin6_in;
  logic            strap_o;
  logic [31:0]     rd;
  int              n_mismatch = 0;
  int              n_compared = 0;
  int              cycles     = 0;

  ppfs_top #(.SYNC_STAGES(2)) i_ppfs_top (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .mrst_b_i(mrst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_g_pin6_pad_i(pad),
    .port_d_role_o(role_d), .port_e_role_o(role_e),
    .port_f_role_o(role_f), .port_g_role_o(role_g),
    .port_g_pin6_input_o(pin6_in), .debug_mode_strap_o(strap_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // a hung handshake would otherwise stall the run forever
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %08h seen %08h", what, expv, seen);
    end
  endtask : chk

  // reserved codes read back as input with pull-up
  function automatic logic [31:0] exp_role(input logic [15:0] w, input logic [7:0] r00,
                                            input logic [7:0] r01, input logic [7:0] impl);
    logic [7:0] a, o, i, p;
    logic [1:0] c;
    {a, o, i, p} = 32'h0;
    for (int n = 0; n < 8; n++) begin
      c = w[2*n +: 2];
      if ((c == 2'h0 && r00[n]) || (c == 2'h1 && r01[n])) c = 2'h2;
      a[n] = impl[n] & (c == 2'h0);
      o[n] = impl[n] & (c == 2'h1);
      i[n] = impl[n] & c[1];
      p[n] = impl[n] & (c == 2'h2);
    end
    return {a, o, i, p};
  endfunction : exp_role

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      final_report();
    end else begin
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk_i);
    end
  endtask : wb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] expv);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(what, rd, expv);
  endtask : rdchk

  task automatic rolechk(input logic [7:0] a, input logic [15:0] w);
    logic [31:0] seen, expv;
    @(negedge mclk_i);
    case (a)
      `PPFS_OFS_D: begin
        seen = role_d;
        expv = exp_role(w, 8'h00, 8'h50, 8'h50);
      end
      `PPFS_OFS_E: begin
        seen = role_e;
        expv = exp_role(w, 8'hCB, 8'h00, 8'hFF);
      end
      `PPFS_OFS_F: begin
        seen = role_f;
        expv = exp_role(w, 8'h00, 8'hFF, 8'hFF);
      end
      default: begin
        seen = role_g;
        expv = exp_role({w[15:2], w[3], w[0]}, 8'h00, 8'hFF, 8'hFF);
      end
    endcase
    chk("pin roles", seen, expv);
    @(posedge mclk_i);
  endtask : rolechk

  task automatic por(input logic s);
    rst_b_i <= 1'b0;
    pad     <= s;
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask : por

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset(input logic s, input logic [15:0] e, f, g, input logic [7:0] st);
    por(s);
    rdchk("d word", `PPFS_OFS_D, 32'h0000_2200);
    rdchk("e word", `PPFS_OFS_E, {16'h0, e});
    rdchk("f word", `PPFS_OFS_F, {16'h0, f});
    rdchk("g word", `PPFS_OFS_G, {16'h0, g});
    rdchk("status", `PPFS_OFS_STAT, {24'h0, st});
    chk("strap", {31'h0, strap_o}, {31'h0, s});
    rolechk(`PPFS_OFS_D, 16'h2200);
    rolechk(`PPFS_OFS_E, e);
    rolechk(`PPFS_OFS_F, f);
    rolechk(`PPFS_OFS_G, g);
    $display("test reset strap %0d done", s);
  endtask : t_reset

  // every code on every port E pin, then a manual reset
  task automatic t_codes;
    logic [15:0] w;
    for (int c = 0; c < 4; c++) begin
      w = {8{c[1:0]}};
      wb(1'b1, `PPFS_OFS_E, {16'hFFFF, w}, 4'hF);
      rdchk("e code", `PPFS_OFS_E, {16'h0, w});
      rolechk(`PPFS_OFS_E, w);
    end
    mrst_b_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    mrst_b_i <= 1'b1;
    @(posedge mclk_i);
    rdchk("e kept", `PPFS_OFS_E, 32'h0000_FFFF);
    rdchk("f kept", `PPFS_OFS_F, 32'h0000_00AA);
    $display("test codes done");
  endtask : t_codes

  task automatic t_bytes;
    wb(1'b1, `PPFS_OFS_F, 32'h0000_FF1B, 4'h1);
    rdchk("f low byte", `PPFS_OFS_F, 32'h0000_001B);
    rolechk(`PPFS_OFS_F, 16'h001B);
    rdchk("status rsv", `PPFS_OFS_STAT, 32'h0000_0040);
    wb(1'b1, `PPFS_OFS_F, 32'h0000_551B, 4'h2);
    rdchk("f high byte", `PPFS_OFS_F, 32'h0000_551B);
    rolechk(`PPFS_OFS_F, 16'h551B);
    $display("test bytes done");
  endtask : t_bytes

  task automatic t_gpin0;
    logic [15:0] w;
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 16'h0002 : (k == 1) ? 16'h0009 : 16'h1588;
      wb(1'b1, `PPFS_OFS_G, {16'h0, w}, 4'hF);
      rdchk("g word", `PPFS_OFS_G, {16'h0, w});
      rolechk(`PPFS_OFS_G, w);
    end
    $display("test g pin0 done");
  endtask : t_gpin0

  task automatic t_misc;
    wb(1'b1, 8'h14, 32'h0000_FFFF, 4'hF);
    rdchk("unmapped", 8'h14, 32'h0);
    wb(1'b1, `PPFS_OFS_D, 32'hFFFF_FFFF, 4'hF);
    rdchk("d mask", `PPFS_OFS_D, 32'h0000_3300);
    rolechk(`PPFS_OFS_D, 16'h3300);
    wb(1'b1, `PPFS_OFS_D, 32'h0000_1100, 4'hF);
    rolechk(`PPFS_OFS_D, 16'h1100);
    $display("test misc done");
  endtask : t_misc

  // pad turns plain input after reset; captured strap must not follow it
  task automatic t_pin6;
    for (int k = 0; k < 2; k++) begin
      pad <= (k == 0);
      repeat (4) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("pin6 input", {31'h0, pin6_in}, {31'h0, k == 0});
      chk("strap held", {31'h0, strap_o}, 32'h0);
      @(posedge mclk_i);
    end
    $display("test pin6 done");
  endtask : t_pin6

  initial begin
    rst_b_i  = 1'b0;
    mrst_b_i = 1'b1;
    {cyc, stb, we, sel, adr, wdat} = '0;
    pad      = 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_reset(1'b1, 16'hAAAA, 16'hAAAA, 16'hAAAA, 8'h01);
    t_reset(1'b0, 16'h2AA8, 16'h00AA, 16'hA200, 8'h20);
    t_codes();
    t_bytes();
    t_gpin0();
    t_misc();
    t_pin6();
    final_report();
  end
endmodule : ppfs_top_test
